/* bpwei_pkg.sv */
package bpwei_pkg;

  // Port geometry
  localparam int NPIN = 8;
  localparam int NVEC = 7;
  localparam int AW = 3;

  // Register indices on the plain register port
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DIR = 3'h1;
  localparam logic [2:0] REG_OPT = 3'h2;
  localparam logic [2:0] REG_SENS_LO = 3'h3;
  localparam logic [2:0] REG_SENS_HI = 3'h4;
  localparam logic [2:0] REG_PEND = 3'h5;
  localparam logic [2:0] REG_LEVEL = 3'h6;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_SENS = 14'h0000;
  localparam logic [7:0] RST_OE_N = 8'hff;

  // Field layout of the two sensitivity registers
  localparam int SENS_W = 2;
  localparam int SENS_LO_W = 8;
  localparam int SENS_HI_W = 6;

  // Sensitivity codes per vector
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;

  // Pins without pull-up or high-side driver
  localparam logic [7:0] TRUE_OD_MASK = 8'h50;

  // Vector of each pin, three bits per pin, pin 0 lowest
  localparam logic [23:0] PIN_VEC_MAP = {3'h0, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // State of one vector detector
  typedef struct packed {
    logic prev;
    logic pend;
  } bpwei_det_st_t;

  // State of the port
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [13:0] sens;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] pin_out;
    logic [7:0] oe_n;
    logic [7:0] pull;
    logic [7:0] alt_in;
    logic [7:0] rdata;
    logic [6:0] irq;
    logic wake;
  } bpwei_port_st_t;

endpackage : bpwei_pkg

/* bpwei_vec_det.sv */
`timescale 1ns/1ps
module bpwei_vec_det (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic lvl_in,
  input wire logic [1:0] sens_in,
  input wire logic fetch_in,
  input wire logic discard_in,
  output logic pend_out
);
  import bpwei_pkg::*;

  bpwei_det_st_t s_r;
  bpwei_det_st_t s_nxt;
  logic rise;
  logic fall;
  logic hit;

  // Event detection and request latch
  always_comb begin
    s_nxt = s_r;
    rise = ~s_r.prev & lvl_in;
    fall = s_r.prev & ~lvl_in;
    unique case (sens_in)
      SENS_FALL_LOW: hit = ~lvl_in; // RL22
      SENS_RISE: hit = rise; // RL22
      SENS_FALL: hit = fall; // RL22
      SENS_BOTH: hit = rise | fall; // RL22
    endcase
    s_nxt.prev = lvl_in;
    if (discard_in) begin
      s_nxt.pend = 1'b0; // RL9
    end else begin
      s_nxt.pend = hit | (s_r.pend & ~fetch_in); // RL8
    end
  end

  // State register; idle line level is high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{prev: 1'b1, pend: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pend_out = s_r.pend;

endmodule : bpwei_vec_det

/* bpwei_port.sv */
`timescale 1ns/1ps
// Contract
// [RL1] Input pin: data read returns the synchronised live pin level.
// [RL2] Data writes always update the latch, pin untouched while input.
// [RL3] Software avoids bit set or clear on the data latch.
// [RL4] Option bit on an input pin makes it an interrupt input.
// [RL5] Each vector has its own sensitivity code in a control register.
// [RL6] Seven vectors; several pins may share one vector.
// [RL7] Enabled pins on one vector are ANDed before event detection.
// [RL8] Vector fetch clears that vector's request latch.
// [RL9] Changing a vector's sensitivity discards its pending request.
// [RL10] Request reaches processor only if pin configured and mask clear.
// [RL11] Output pin drives the latch; read returns the latch.
// [RL12] Push-pull drives both levels; open-drain drives low, floats high.
// [RL13] Peripheral output enable forces output and overrides port settings.
// [RL14] Input pin with peripheral output: read returns peripheral output.
// [RL15] Output pin with peripheral input: peripheral sees the latch.
// [RL16] Software uses floating input without interrupt for alternate inputs.
// [RL17] Software selects floating input before analog use.
// [RL18] True open-drain pins never pull up nor drive high.
// [RL19] Pins keep state in low-power modes; events raise wake.
// [RL20] Direction/option: 00 float, 01 pull-up irq, 10 open-drain, 11 push-pull.
// [RL21] Data, direction and option reset to zero.
// [RL22] Sensitivity: 00 fall+low, 01 rise, 10 fall, 11 both.
// [RL23] True open-drain: 00 float, 01 float irq, 1x open-drain.
// [RL24] Pin inputs pass two flip-flops before any use.
module bpwei_port (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [bpwei_pkg::AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n_out,
  output logic [7:0] pull_up_out,
  input wire logic [7:0] alt_oe_in,
  input wire logic [7:0] alt_out_in,
  output logic [7:0] alt_in_out,
  input wire logic [bpwei_pkg::NVEC-1:0] vec_fetch_in,
  input wire logic cond_code_mask_in,
  output logic [bpwei_pkg::NVEC-1:0] irq_req_out,
  output logic wake_out
);
  import bpwei_pkg::*;

  bpwei_port_st_t s_r;
  bpwei_port_st_t s_nxt;

  // Combined level per vector and sensitivity-change discard
  logic [NVEC-1:0] vec_lvl;
  logic [NVEC-1:0] vec_discard;
  logic [NVEC-1:0] vec_pend;

  // Per-pin decode helpers
  logic [7:0] irq_en;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] push_pull;
  logic [7:0] rd_view;

  // Main next-state logic
  always_comb begin
    s_nxt = s_r;
    vec_lvl = '1;
    vec_discard = '0;
    irq_en = '0;
    drive_en = '0;
    drive_val = '0;
    push_pull = '0;
    rd_view = '0;

    // Two-stage synchroniser on the pads
    s_nxt.sync1 = pin_in; // RL24
    s_nxt.sync2 = s_r.sync1; // RL24

    // Interrupt input when direction is 0 and option is 1
    irq_en = ~s_r.dir & s_r.opt; // RL4 RL20 RL23

    // AND the enabled pins of each vector; idle vectors sit high
    for (int v = 0; v < NVEC; v++) begin
      for (int i = 0; i < NPIN; i++) begin
        if (irq_en[i] && PIN_VEC_MAP[3*i +: 3] == 3'(v)) begin
          vec_lvl[v] = vec_lvl[v] & s_r.sync2[i]; // RL6 RL7
        end
      end
    end

    // Pad control per pin
    for (int i = 0; i < NPIN; i++) begin
      // Peripheral output takes the pin over
      drive_en[i] = alt_oe_in[i] | s_r.dir[i]; // RL13 RL11
      drive_val[i] = alt_oe_in[i] ? alt_out_in[i] : s_r.data[i]; // RL13
      // Push-pull only where a high-side driver exists
      push_pull[i] = ~TRUE_OD_MASK[i] & (alt_oe_in[i] | s_r.opt[i]); // RL18 RL20 RL23
      if (!drive_en[i]) begin
        // Input: released pad, latch kept for later
        s_nxt.pin_out[i] = 1'b0; // RL2
        s_nxt.oe_n[i] = 1'b1; // RL1
      end else if (push_pull[i]) begin
        s_nxt.pin_out[i] = drive_val[i]; // RL12
        s_nxt.oe_n[i] = 1'b0; // RL12
      end else begin
        // Open-drain: pull low for 0, float for 1
        s_nxt.pin_out[i] = 1'b0; // RL12
        s_nxt.oe_n[i] = drive_val[i]; // RL12
      end
      // Pull-up only on an input with option set, never on true open-drain
      s_nxt.pull[i] = ~drive_en[i] & s_r.opt[i] & ~TRUE_OD_MASK[i]; // RL18 RL20
      // Peripheral input sees the latch on an output pin
      if (s_r.dir[i] && !alt_oe_in[i]) begin
        s_nxt.alt_in[i] = s_r.data[i]; // RL15
      end else begin
        s_nxt.alt_in[i] = s_r.sync2[i];
      end
      // Data read view
      if (alt_oe_in[i]) begin
        rd_view[i] = alt_out_in[i]; // RL14 RL13
      end else if (s_r.dir[i]) begin
        rd_view[i] = s_r.data[i]; // RL11
      end else begin
        rd_view[i] = s_r.sync2[i]; // RL1
      end
    end

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        REG_DATA: s_nxt.data = wdata_in; // RL2
        REG_DIR: s_nxt.dir = wdata_in;
        REG_OPT: s_nxt.opt = wdata_in;
        REG_SENS_LO: s_nxt.sens[SENS_LO_W-1:0] = wdata_in; // RL5
        REG_SENS_HI: s_nxt.sens[13:SENS_LO_W] = wdata_in[SENS_HI_W-1:0]; // RL5
        default: ;
      endcase
    end

    // A changed code throws away the pending request of that vector
    for (int v = 0; v < NVEC; v++) begin
      vec_discard[v] = s_nxt.sens[SENS_W*v +: SENS_W] != s_r.sens[SENS_W*v +: SENS_W]; // RL9
    end

    // Register reads, data valid only in the following cycle
    s_nxt.rdata = RST_BYTE;
    if (rd_in) begin
      unique case (addr_in)
        REG_DATA: s_nxt.rdata = rd_view;
        REG_DIR: s_nxt.rdata = s_r.dir;
        REG_OPT: s_nxt.rdata = s_r.opt;
        REG_SENS_LO: s_nxt.rdata = s_r.sens[SENS_LO_W-1:0];
        REG_SENS_HI: s_nxt.rdata = {2'h0, s_r.sens[13:SENS_LO_W]};
        REG_PEND: s_nxt.rdata = {1'b0, vec_pend};
        REG_LEVEL: s_nxt.rdata = s_r.sync2;
        default: s_nxt.rdata = RST_BYTE;
      endcase
    end

    // Requests gated by the processor mask; wake ignores the mask
    s_nxt.irq = vec_pend & {NVEC{~cond_code_mask_in}}; // RL10
    s_nxt.wake = |vec_pend; // RL19
  end

  // One detector per vector
  for (genvar v = 0; v < NVEC; v++) begin : g_vec
    bpwei_vec_det u_det (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .lvl_in(vec_lvl[v]),
      .sens_in(s_r.sens[SENS_W*v +: SENS_W]),
      .fetch_in(vec_fetch_in[v]),
      .discard_in(vec_discard[v]),
      .pend_out(vec_pend[v])
    );
  end

  // State register; all pins start as floating inputs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r.data <= RST_BYTE; // RL21
      s_r.dir <= RST_BYTE; // RL21
      s_r.opt <= RST_BYTE; // RL21
      s_r.sens <= RST_SENS;
      s_r.sync1 <= RST_BYTE;
      s_r.sync2 <= RST_BYTE;
      s_r.pin_out <= RST_BYTE;
      s_r.oe_n <= RST_OE_N;
      s_r.pull <= RST_BYTE;
      s_r.alt_in <= RST_BYTE;
      s_r.rdata <= RST_BYTE;
      s_r.irq <= '0;
      s_r.wake <= 1'b0;
    end else begin
      s_r <= s_nxt; // RL19
    end
  end

  // Outputs straight from flip-flops
  assign rdata_out = s_r.rdata;
  assign pin_out = s_r.pin_out;
  assign pin_oe_n_out = s_r.oe_n;
  assign pull_up_out = s_r.pull;
  assign alt_in_out = s_r.alt_in;
  assign irq_req_out = s_r.irq;
  assign wake_out = s_r.wake;

endmodule : bpwei_port

/* bpwei_port_checker.sv */
`timescale 1ns/1ps
module bpwei_port_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [bpwei_pkg::AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n_out,
  input wire logic [7:0] pull_up_out,
  input wire logic [7:0] alt_oe_in,
  input wire logic [7:0] alt_out_in,
  input wire logic cond_code_mask_in,
  input wire logic [bpwei_pkg::NVEC-1:0] irq_req_out,
  input wire logic wake_out
);
  import bpwei_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Pad drive limits
  a_truod_no_pull: assert property ((pull_up_out & TRUE_OD_MASK) == 8'h00)
    else $error("pull-up on open-drain pin");
  a_truod_no_high: assert property ((pin_out & TRUE_OD_MASK) == 8'h00)
    else $error("open-drain pin driven high");
  a_released_low: assert property ((pin_out & pin_oe_n_out) == 8'h00)
    else $error("released pin carries drive value");
  a_alt_drive: assert property (alt_oe_in[1] |=> !pin_oe_n_out[1] && pin_out[1] == $past(alt_out_in[1]))
    else $error("peripheral output not on pad");
  // Requests and reads
  a_mask_blocks: assert property (cond_code_mask_in |=> irq_req_out == 7'h00)
    else $error("request passed while masked");
  a_irq_wake: assert property (|irq_req_out |-> wake_out)
    else $error("request without wake");
  a_dir_readback: assert property (wr_in && addr_in == REG_DIR ##1 rd_in && addr_in == REG_DIR
    |=> rdata_out == $past(wdata_in, 2))
    else $error("direction readback wrong");
  a_level_sync: assert property (rd_in && addr_in == REG_LEVEL && pin_in == $past(pin_in) && pin_in == $past(pin_in, 2)
    |=> rdata_out == $past(pin_in))
    else $error("synced level wrong");
endmodule : bpwei_port_checker

bind bpwei_port bpwei_port_checker bpwei_port_checker_i (.clk_in(clk_in), .rstn_in(rstn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .pull_up_out(pull_up_out),
  .alt_oe_in(alt_oe_in), .alt_out_in(alt_out_in), .cond_code_mask_in(cond_code_mask_in),
  .irq_req_out(irq_req_out), .wake_out(wake_out));

/* bpwei_board.sv */
`timescale 1ns/1ps
module bpwei_board (
  input wire logic [7:0] ext_lvl_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] oe_n_in,
  output logic [7:0] pin_lvl_out
);
  // Device drive wins on enabled pins, board source elsewhere
  assign pin_lvl_out = (~oe_n_in & pin_out_in) | (oe_n_in & ext_lvl_in);
endmodule : bpwei_board

/* tb_bpwei_port.sv */
`timescale 1ns/1ps
module tb_bpwei_port;
  import bpwei_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [AW-1:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] alt_oe_in = 8'h00;
  logic [7:0] alt_out_in = 8'h00;
  logic [NVEC-1:0] vec_fetch_in = 7'h00;
  logic cond_code_mask_in = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] rdata_out, pin_in, pin_out, pin_oe_n_out, pull_up_out, alt_in_out;
  logic [NVEC-1:0] irq_req_out;
  logic wake_out;
  logic [1:0] c;
  int err_count = 0;
  int n_tests = 0;

  always #25 clk_in = ~clk_in;

  bpwei_port bpwei_port_i (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .pull_up_out(pull_up_out), .alt_oe_in(alt_oe_in),
    .alt_out_in(alt_out_in), .alt_in_out(alt_in_out), .vec_fetch_in(vec_fetch_in),
    .cond_code_mask_in(cond_code_mask_in), .irq_req_out(irq_req_out), .wake_out(wake_out));
  bpwei_board bpwei_board_i (.ext_lvl_in(ext), .pin_out_in(pin_out), .oe_n_in(pin_oe_n_out),
    .pin_lvl_out(pin_in));

  // Bus cycles, idle cycles and compares
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
    @(negedge clk_in);
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    cyc(1);
    chk(rdata_out, exp);
  endtask : rd
  task automatic setx(input logic [7:0] v);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    ext <= v;
  endtask : setx
  task automatic fetch(input logic [6:0] m);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    vec_fetch_in <= m;
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    vec_fetch_in <= 7'h00;
  endtask : fetch

  task automatic t_reset();
    rd(REG_DIR, 8'h00);
    rd(REG_OPT, 8'h00);
    chk(pin_oe_n_out, 8'hff);
    wr(REG_SENS_HI, 8'hff);
    rd(REG_SENS_HI, 8'h3f);
    wr(REG_SENS_HI, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_io();
    setx(8'h3c);
    wr(REG_DATA, 8'hff);
    cyc(4);
    chk(pin_oe_n_out, 8'hff);
    rd(REG_DATA, 8'h3c);
    rd(REG_LEVEL, 8'h3c);
    wr(REG_OPT, 8'hff);
    wr(REG_DIR, 8'hff);
    rd(REG_DIR, 8'hff);
    cyc(1);
    chk(pin_oe_n_out, 8'h50);
    chk(pin_out, 8'haf);
    rd(REG_DATA, 8'hff);
    wr(REG_OPT, 8'h00);
    wr(REG_DATA, 8'h5a);
    cyc(2);
    chk(pin_oe_n_out, 8'h5a);
    chk(pin_out, 8'h00);
    chk(alt_in_out, 8'h5a);
    $display("test io done");
  endtask : t_io
  task automatic t_alt();
    wr(REG_DIR, 8'h00);
    alt_oe_in <= 8'h42;
    alt_out_in <= 8'h42;
    cyc(3);
    chk(pin_oe_n_out, 8'hfd);
    rd(REG_DATA, 8'h7e);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    alt_oe_in <= 8'h00;
    $display("test alt done");
  endtask : t_alt
  task automatic t_pull();
    wr(REG_OPT, 8'hff);
    cyc(2);
    chk(pull_up_out, 8'haf);
    $display("test pull done");
  endtask : t_pull
  task automatic t_irq();
    wr(REG_OPT, 8'h01);
    setx(8'h00);
    cyc(4);
    fetch(7'h7f);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i + 1);
      wr(REG_SENS_LO, {6'h00, c});
      setx(8'h01);
      cyc(5);
      rd(REG_PEND, {7'h00, c != SENS_FALL});
      fetch(7'h01);
      rd(REG_PEND, 8'h00);
      setx(8'h00);
      cyc(5);
      chk({wake_out, irq_req_out}, {c != SENS_RISE, 6'h00, c != SENS_RISE});
    end
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    cond_code_mask_in <= 1'b1;
    cyc(2);
    chk({wake_out, irq_req_out}, 8'h80);
    setx(8'h01);
    cond_code_mask_in <= 1'b0;
    cyc(4);
    wr(REG_SENS_LO, 8'h02);
    rd(REG_PEND, 8'h00);
    setx(8'h81);
    wr(REG_OPT, 8'h81);
    setx(8'h01);
    cyc(5);
    fetch(7'h01);
    setx(8'h00);
    cyc(5);
    rd(REG_PEND, 8'h00);
    $display("test irq done");
  endtask : t_irq

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_io();
    t_alt();
    t_pull();
    t_irq();
    wrap_up();
  end
endmodule : tb_bpwei_port
